// ### msadc_host.sv
// controller end: apb registers driving trigger, mode commands and counter readout
`timescale 1ns/1ps
module msadc_host
  import msadc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  msadc_if.host            link
);

  // synchronisers for lines from the device
  logic [2:0] done_sy;
  logic [2:0] deint_sy;
  logic [1:0] miso_sy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_sy  <= 3'h7;
      deint_sy <= 3'h7;
      miso_sy  <= 2'h3;
    end else begin
      done_sy  <= {done_sy[1:0], link.done_n};
      deint_sy <= {deint_sy[1:0], link.deintegrate_start_n};
      miso_sy  <= {miso_sy[0], link.miso};
    end
  end

  logic acc;
  logic wr;
  assign acc = psel & penable & ~pready;
  assign wr  = psel & penable & pready & pwrite;

  // link sequencer, apb registers and event flags
  msadc_hstate_t         st_reg;
  msadc_hstate_t         st_next;
  logic [TMR_W-1:0]      tmr_reg;
  logic [TMR_W-1:0]      tmr_next;
  logic [BITCNT_W-1:0]   bit_reg;
  logic [BITCNT_W-1:0]   bit_next;
  logic [FRAME_BITS-1:0] rx_reg;
  logic [FRAME_BITS-1:0] rx_next;
  logic [1:0]            cmd_reg;
  logic [1:0]            cmd_next;
  logic                  trig_reg;
  logic                  trig_next;
  logic                  stb_reg;
  logic                  stb_next;
  logic                  sclk_reg;
  logic                  sclk_next;
  logic                  cs_n_reg;
  logic                  cs_n_next;
  logic [EV_W-1:0]       stat_reg;
  logic [EV_W-1:0]       stat_next;
  logic [EV_W-1:0]       mask_reg;
  logic [EV_W-1:0]       mask_next;
  logic [CNT_W-1:0]      pos_reg;
  logic [CNT_W-1:0]      pos_next;
  logic [CNT_W-1:0]      neg_reg;
  logic [CNT_W-1:0]      neg_next;
  logic [31:0]           rd_reg;
  logic [31:0]           rd_next;
  logic                  rdy_reg;
  logic                  err_reg;
  logic                  err_next;
  logic                  irq_reg;
  logic [EV_W-1:0]       ev;

  always_comb begin
    st_next   = st_reg;
    tmr_next  = tmr_reg + 1'b1;
    bit_next  = bit_reg;
    rx_next   = rx_reg;
    cmd_next  = cmd_reg;
    trig_next = trig_reg;
    stb_next  = stb_reg;
    sclk_next = sclk_reg;
    cs_n_next = cs_n_reg;
    pos_next  = pos_reg;
    neg_next  = neg_reg;
    mask_next = mask_reg;
    ev        = '0;
    ev[ST_DONE]  = done_sy[2] & ~done_sy[1];
    ev[ST_DEINT] = deint_sy[2] & ~deint_sy[1];
    // trigger is software's level; keep it up for back-to-back readings
    if (wr && paddr == OFS_CTRL) begin
      trig_next = pwdata[0];
    end
    if (wr && paddr == OFS_MASK) begin
      mask_next = pwdata[EV_W-1:0];
    end
    case (st_reg)
      MSADC_H_IDLE: begin
        tmr_next = '0;
        if (wr && paddr == OFS_CMD) begin
          cmd_next = pwdata[1:0];
          st_next  = MSADC_H_CMD_SET;
        end else if (wr && paddr == OFS_READ) begin
          cs_n_next = 1'b0;
          bit_next  = '0;
          st_next   = MSADC_H_RD_LOW;
        end
      end
      MSADC_H_CMD_SET: begin
        // bits settle before the strobe edge
        if (tmr_reg == TMR_W'(CMD_SETUP_CYC - 1)) begin
          stb_next = 1'b1;
          tmr_next = '0;
          st_next  = MSADC_H_CMD_STB;
        end
      end
      MSADC_H_CMD_STB: begin
        if (tmr_reg == TMR_W'(STB_HIGH_CYC - 1)) begin
          stb_next = 1'b0;
          tmr_next = '0;
          st_next  = MSADC_H_CMD_HLD;
        end
      end
      MSADC_H_CMD_HLD: begin
        if (tmr_reg == TMR_W'(STB_HOLD_CYC - 1)) begin
          st_next = MSADC_H_IDLE;
        end
      end
      MSADC_H_RD_LOW: begin
        if (tmr_reg == TMR_W'(SCLK_HALF_CYC - 1)) begin
          sclk_next = 1'b1;
          tmr_next  = '0;
          st_next   = MSADC_H_RD_HIGH;
        end
      end
      MSADC_H_RD_HIGH: begin
        // sampled after this case, late in the high half to cover both synchroniser delays
      end
      default: begin
        st_next = MSADC_H_IDLE;
      end
    endcase
    if (st_reg == MSADC_H_RD_HIGH && tmr_reg == TMR_W'(SCLK_HALF_CYC - 1)) begin
      rx_next   = {rx_reg[FRAME_BITS-2:0], miso_sy[1]};
      sclk_next = 1'b0;
      tmr_next  = '0;
      bit_next  = bit_reg + 1'b1;
      st_next   = MSADC_H_RD_LOW;
      if (bit_reg == BITCNT_W'(FRAME_BITS - 1)) begin
        cs_n_next = 1'b1;
        st_next   = MSADC_H_IDLE;
        pos_next  = rx_next[FRAME_BITS-1:CNT_W];
        neg_next  = rx_next[CNT_W-1:0];
        ev[ST_RDDONE] = 1'b1;
      end
    end
    // set wins over a simultaneous write-one clear
    stat_next = stat_reg;
    if (wr && paddr == OFS_STATUS) begin
      stat_next = stat_reg & ~pwdata[EV_W-1:0];
    end
    stat_next = stat_next | ev;
  end

  // apb read data captured in the first access cycle, answered the next
  always_comb begin
    rd_next  = 32'h0000_0000;
    err_next = 1'b0;
    case (paddr)
      OFS_CTRL:   rd_next = {31'h0000_0000, trig_reg};
      OFS_CMD:    rd_next = {30'h0000_0000, cmd_reg};
      OFS_READ:   rd_next = 32'h0000_0000;
      OFS_STATUS: begin
        rd_next[EV_W-1:0] = stat_reg;
        rd_next[ST_BUSY]  = (st_reg != MSADC_H_IDLE);
        // live done level tells software whether the readout beat the clear
        rd_next[ST_DONE_L] = done_sy[1];
        rd_next[ST_DEIN_L] = deint_sy[1];
      end
      OFS_MASK:   rd_next = {29'h0000_0000, mask_reg};
      OFS_POS:    rd_next = {12'h000, pos_reg};
      OFS_NEG:    rd_next = {12'h000, neg_reg};
      default:    err_next = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg   <= MSADC_H_IDLE;
      tmr_reg  <= '0;
      bit_reg  <= '0;
      rx_reg   <= '0;
      cmd_reg  <= MODE_RST;
      trig_reg <= 1'b0;
      stb_reg  <= 1'b0;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      stat_reg <= '0;
      mask_reg <= '0;
      pos_reg  <= '0;
      neg_reg  <= '0;
      rd_reg   <= 32'h0000_0000;
      rdy_reg  <= 1'b0;
      err_reg  <= 1'b0;
      irq_reg  <= 1'b0;
    end else begin
      st_reg   <= st_next;
      tmr_reg  <= tmr_next;
      bit_reg  <= bit_next;
      rx_reg   <= rx_next;
      cmd_reg  <= cmd_next;
      trig_reg <= trig_next;
      stb_reg  <= stb_next;
      sclk_reg <= sclk_next;
      cs_n_reg <= cs_n_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      pos_reg  <= pos_next;
      neg_reg  <= neg_next;
      rd_reg   <= acc ? rd_next : rd_reg;
      rdy_reg  <= acc;
      err_reg  <= acc ? err_next : 1'b0;
      irq_reg  <= |(stat_next & mask_next);
    end
  end

  assign prdata           = rd_reg;
  assign pready           = rdy_reg;
  assign pslverr          = err_reg & rdy_reg;
  assign irq              = irq_reg;
  assign link.trigger     = trig_reg;
  assign link.mode_cmd_hi = cmd_reg[1];
  assign link.mode_cmd_lo = cmd_reg[0];
  assign link.cmd_strobe  = stb_reg;
  assign link.sclk        = sclk_reg;
  assign link.cs_n        = cs_n_reg;

endmodule

// ### msadc_pkg.sv
// package: constants and types shared by the converter sequencer and its controller
package msadc_pkg;
  // counter and frame layout: two counters packed into five bytes
  localparam int CNT_W      = 20;
  localparam int FRAME_BITS = 40;
  localparam int BITCNT_W   = 6;
  localparam int TMR_W      = 16;

  // default phase lengths in pclk cycles
  localparam int AZ_CYC_DEF    = 200;
  localparam int INT_CYC_DEF   = 400;
  localparam int DEINT_CYC_DEF = 400;

  // clock and serial timing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int SCLK_PERIOD_NS = 320;
  localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / CLK_PERIOD_NS / 2;
  localparam int CMD_SETUP_CYC  = 4;
  localparam int STB_HIGH_CYC   = 4;
  localparam int STB_HOLD_CYC   = 4;

  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_READ   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_MASK   = 8'h10;
  localparam logic [7:0] OFS_POS    = 8'h14;
  localparam logic [7:0] OFS_NEG    = 8'h18;

  // status bit positions
  localparam int ST_DONE   = 0;
  localparam int ST_DEINT  = 1;
  localparam int ST_RDDONE = 2;
  localparam int ST_BUSY   = 3;
  localparam int ST_DONE_L = 4;
  localparam int ST_DEIN_L = 5;
  localparam int EV_W      = 3;

  // reset values
  localparam logic [1:0] MODE_RST = 2'b00;

  typedef enum logic [1:0] {
    MSADC_MEASURE     = 2'b00,
    MSADC_REFBAL_BOTH = 2'b01,
    MSADC_REFBAL_NONE = 2'b10,
    MSADC_RESERVED    = 2'b11
  } msadc_mode_t;

  typedef enum logic [1:0] {
    MSADC_UNTIMED_AZ  = 2'b00,
    MSADC_AUTOZERO    = 2'b01,
    MSADC_INTEGRATE   = 2'b10,
    MSADC_DEINTEGRATE = 2'b11
  } msadc_phase_t;

  typedef enum logic [2:0] {
    MSADC_H_IDLE    = 3'b000,
    MSADC_H_CMD_SET = 3'b001,
    MSADC_H_CMD_STB = 3'b010,
    MSADC_H_CMD_HLD = 3'b011,
    MSADC_H_RD_LOW  = 3'b100,
    MSADC_H_RD_HIGH = 3'b101
  } msadc_hstate_t;
endpackage

// ### msadc_if.sv
// interface: trigger, command port, status lines and shared serial port between the two ends
`timescale 1ns/1ps
interface msadc_if;
  logic trigger;
  logic mode_cmd_hi;
  logic mode_cmd_lo;
  logic cmd_strobe;
  logic done_n;
  logic deintegrate_start_n;
  logic sclk;
  logic cs_n;
  logic sdo;
  logic sdo_oe_n;
  logic miso;

  // shared data line idles high when nobody drives it
  assign miso = sdo_oe_n ? 1'b1 : sdo;

  modport dev (
    input  trigger, mode_cmd_hi, mode_cmd_lo, cmd_strobe, sclk, cs_n,
    output done_n, deintegrate_start_n, sdo, sdo_oe_n
  );
  modport host (
    output trigger, mode_cmd_hi, mode_cmd_lo, cmd_strobe, sclk, cs_n,
    input  done_n, deintegrate_start_n, miso
  );
endinterface

// ### msadc_device.sv
// device end: multi-slope converter phase sequencer, reference time counters, serial readout
`timescale 1ns/1ps
module msadc_device
  import msadc_pkg::*;
#(
  parameter int AZ_CYC    = AZ_CYC_DEF,
  parameter int INT_CYC   = INT_CYC_DEF,
  parameter int DEINT_CYC = DEINT_CYC_DEF
)(
  input  wire logic pclk,
  input  wire logic presetn,
  msadc_if.dev      link,
  input  wire logic cmp_pos,
  output logic      az_sw_on,
  output logic      input_sw_on,
  output logic      pos_ref_on,
  output logic      neg_ref_on
);

  // synchroniser chains, bit 0 is the first flop and feeds only bit 1
  logic [2:0] trig_sy;
  logic [2:0] stb_sy;
  logic [2:0] sclk_sy;
  logic [2:0] cs_sy;
  logic [1:0] chi_sy;
  logic [1:0] clo_sy;
  logic [1:0] cmp_sy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_sy <= 3'h0;
      stb_sy  <= 3'h0;
      sclk_sy <= 3'h0;
      cs_sy   <= 3'h7;
      chi_sy  <= 2'h0;
      clo_sy  <= 2'h0;
      cmp_sy  <= 2'h0;
    end else begin
      trig_sy <= {trig_sy[1:0], link.trigger};
      stb_sy  <= {stb_sy[1:0], link.cmd_strobe};
      sclk_sy <= {sclk_sy[1:0], link.sclk};
      cs_sy   <= {cs_sy[1:0], link.cs_n};
      chi_sy  <= {chi_sy[0], link.mode_cmd_hi};
      clo_sy  <= {clo_sy[0], link.mode_cmd_lo};
      cmp_sy  <= {cmp_sy[0], cmp_pos};
    end
  end

  logic trig;
  logic stb_rise;
  logic sclk_fall;
  logic cs_fall;
  assign trig      = trig_sy[1];
  assign stb_rise  = stb_sy[1] & ~stb_sy[2];
  assign sclk_fall = sclk_sy[2] & ~sclk_sy[1] & ~cs_sy[1];
  assign cs_fall   = cs_sy[2] & ~cs_sy[1];

  // mode register; data lines are settled before the strobe, so their sync lags harmlessly
  msadc_mode_t mode_reg;
  msadc_mode_t mode_next;
  logic [1:0]  cmd_code;
  assign cmd_code = {chi_sy[1], clo_sy[1]};

  always_comb begin
    mode_next = mode_reg;
    if (stb_rise && cmd_code != MSADC_RESERVED) begin
      mode_next = msadc_mode_t'(cmd_code);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= msadc_mode_t'(MODE_RST);
    end else begin
      mode_reg <= mode_next;
    end
  end

  // phase sequencer with counters, switch drives and status lines
  msadc_phase_t     phase_reg;
  msadc_phase_t     phase_next;
  logic [TMR_W-1:0] timer_reg;
  logic [TMR_W-1:0] timer_next;
  logic [CNT_W-1:0] pos_cnt_reg;
  logic [CNT_W-1:0] pos_cnt_next;
  logic [CNT_W-1:0] neg_cnt_reg;
  logic [CNT_W-1:0] neg_cnt_next;
  logic             done_n_reg;
  logic             done_n_next;
  logic             deint_n_reg;
  logic             deint_n_next;
  logic             az_reg;
  logic             az_next;
  logic             input_reg;
  logic             input_next;
  logic             pos_ref_reg;
  logic             pos_ref_next;
  logic             neg_ref_reg;
  logic             neg_ref_next;

  always_comb begin
    phase_next   = phase_reg;
    timer_next   = timer_reg + 1'b1;
    done_n_next  = done_n_reg;
    deint_n_next = deint_n_reg;
    // counters run only while a reference is on; widths chosen so they never wrap
    pos_cnt_next = pos_cnt_reg + CNT_W'(pos_ref_reg);
    neg_cnt_next = neg_cnt_reg + CNT_W'(neg_ref_reg);
    case (phase_reg)
      MSADC_UNTIMED_AZ: begin
        timer_next = '0;
        if (trig) begin
          phase_next = MSADC_AUTOZERO;
        end
      end
      MSADC_AUTOZERO: begin
        if (timer_reg == TMR_W'(AZ_CYC - 1)) begin
          phase_next   = MSADC_INTEGRATE;
          timer_next   = '0;
          pos_cnt_next = '0;
          neg_cnt_next = '0;
          done_n_next  = 1'b1;
        end
      end
      MSADC_INTEGRATE: begin
        if (timer_reg == TMR_W'(INT_CYC - 1)) begin
          phase_next   = MSADC_DEINTEGRATE;
          timer_next   = '0;
          deint_n_next = 1'b0;
        end
      end
      MSADC_DEINTEGRATE: begin
        if (timer_reg == TMR_W'(DEINT_CYC - 1)) begin
          timer_next   = '0;
          done_n_next  = 1'b0;
          deint_n_next = 1'b1;
          // still triggered: next reading starts with no idle gap
          phase_next = trig ? MSADC_AUTOZERO : MSADC_UNTIMED_AZ;
        end
      end
      default: begin
        phase_next = MSADC_UNTIMED_AZ;
        timer_next = '0;
      end
    endcase
    // switch drives follow the phase being entered
    az_next      = (phase_next == MSADC_AUTOZERO) || (phase_next == MSADC_UNTIMED_AZ);
    input_next   = (phase_next == MSADC_INTEGRATE) && (mode_reg == MSADC_MEASURE);
    pos_ref_next = 1'b0;
    neg_ref_next = 1'b0;
    if (phase_next == MSADC_INTEGRATE && mode_reg == MSADC_REFBAL_BOTH) begin
      pos_ref_next = 1'b1;
      neg_ref_next = 1'b1;
    end else if (phase_next == MSADC_DEINTEGRATE && mode_reg != MSADC_REFBAL_NONE) begin
      // drive the integrator back toward zero against its sign
      neg_ref_next = cmp_sy[1];
      pos_ref_next = ~cmp_sy[1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg   <= MSADC_UNTIMED_AZ;
      timer_reg   <= '0;
      pos_cnt_reg <= '0;
      neg_cnt_reg <= '0;
      done_n_reg  <= 1'b1;
      deint_n_reg <= 1'b1;
      az_reg      <= 1'b1;
      input_reg   <= 1'b0;
      pos_ref_reg <= 1'b0;
      neg_ref_reg <= 1'b0;
    end else begin
      phase_reg   <= phase_next;
      timer_reg   <= timer_next;
      pos_cnt_reg <= pos_cnt_next;
      neg_cnt_reg <= neg_cnt_next;
      done_n_reg  <= done_n_next;
      deint_n_reg <= deint_n_next;
      az_reg      <= az_next;
      input_reg   <= input_next;
      pos_ref_reg <= pos_ref_next;
      neg_ref_reg <= neg_ref_next;
    end
  end

  assign az_sw_on                 = az_reg;
  assign input_sw_on              = input_reg;
  assign pos_ref_on               = pos_ref_reg;
  assign neg_ref_on               = neg_ref_reg;
  assign link.done_n              = done_n_reg;
  assign link.deintegrate_start_n = deint_n_reg;

  // serial readout: snapshot at select, shift on each falling serial clock
  logic [FRAME_BITS-1:0] shift_reg;
  logic [FRAME_BITS-1:0] shift_next;
  logic                  sdo_reg;
  logic                  sdo_next;
  logic                  sdo_oe_n_reg;
  logic                  sdo_oe_n_next;

  always_comb begin
    shift_next    = shift_reg;
    sdo_next      = sdo_reg;
    sdo_oe_n_next = cs_sy[1];
    if (cs_fall) begin
      // snapshot keeps the frame coherent if counters clear mid readout
      shift_next = {pos_cnt_reg, neg_cnt_reg};
      sdo_next   = pos_cnt_reg[CNT_W-1];
    end else if (sclk_fall) begin
      shift_next = {shift_reg[FRAME_BITS-2:0], 1'b0};
      sdo_next   = shift_reg[FRAME_BITS-2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg    <= '0;
      sdo_reg      <= 1'b1;
      sdo_oe_n_reg <= 1'b1;
    end else begin
      shift_reg    <= shift_next;
      sdo_reg      <= sdo_next;
      sdo_oe_n_reg <= sdo_oe_n_next;
    end
  end

  assign link.sdo      = sdo_reg;
  assign link.sdo_oe_n = sdo_oe_n_reg;

endmodule

// ### msadc_checker.sv
// checker: phase timing, command strobe and serial framing on the converter link
`timescale 1ns/1ps
module msadc_checker
  import msadc_pkg::*;
#(
  parameter int AZ_CYC    = AZ_CYC_DEF,
  parameter int INT_CYC   = INT_CYC_DEF,
  parameter int DEINT_CYC = DEINT_CYC_DEF
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic trigger,
  input wire logic mode_cmd_hi,
  input wire logic mode_cmd_lo,
  input wire logic cmd_strobe,
  input wire logic done_n,
  input wire logic deintegrate_start_n,
  input wire logic sclk,
  input wire logic cs_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [15:0] cnt_reg, cnt_next;
  logic [6:0]  sck_reg, sck_next;
  logic        done_q_reg, deint_q_reg, sclk_q_reg, armed_reg, armed_next, cont_reg, cont_next;
  logic        done_up, deint_dn, deint_up;

  // one counter restarts at every done rise and deintegrate-start edge, so integrate, deintegrate and retrigger autozero lengths read off it
  always_comb begin
    done_up    = done_n & ~done_q_reg;
    deint_dn   = ~deintegrate_start_n & deint_q_reg;
    deint_up   = deintegrate_start_n & ~deint_q_reg;
    cnt_next   = (done_up | deint_dn | deint_up) ? 16'h0001 : cnt_reg + 16'h0001;
    armed_next = armed_reg | done_up;
    cont_next  = deint_up ? trigger : cont_reg;
    sck_next   = cs_n ? 7'h00 : sck_reg + {6'h00, sclk & ~sclk_q_reg};
  end

  // levels reset to the idle values so no edge is seen at release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg     <= 16'h0000;
      sck_reg     <= 7'h00;
      done_q_reg  <= 1'b1;
      deint_q_reg <= 1'b1;
      sclk_q_reg  <= 1'b0;
      armed_reg   <= 1'b0;
      cont_reg    <= 1'b0;
    end else begin
      cnt_reg     <= cnt_next;
      sck_reg     <= sck_next;
      done_q_reg  <= done_n;
      deint_q_reg <= deintegrate_start_n;
      sclk_q_reg  <= sclk;
      armed_reg   <= armed_next;
      cont_reg    <= cont_next;
    end
  end

  property p_int_len; deint_dn && armed_reg |-> cnt_reg == INT_CYC; endproperty
  a_int_len: assert property (p_int_len) else $error("integrate length off");
  property p_deint_len; deint_up |-> cnt_reg == DEINT_CYC; endproperty
  a_deint_len: assert property (p_deint_len) else $error("deintegrate length off");
  property p_az_len; done_up && cont_reg |-> cnt_reg == AZ_CYC; endproperty
  a_az_len: assert property (p_az_len) else $error("retrigger autozero length off");
  property p_done_low; $fell(done_n) |-> !done_n [*8]; endproperty
  a_done_low: assert property (p_done_low) else $error("done line released early");
  property p_done_in_deint; !deintegrate_start_n |-> done_n; endproperty
  a_done_in_deint: assert property (p_done_in_deint) else $error("done low in deintegrate");
  property p_stb_len; $rose(cmd_strobe) |-> cmd_strobe [*4] ##1 !cmd_strobe; endproperty
  a_stb_len: assert property (p_stb_len) else $error("strobe width off");
  property p_cmd_stable; cmd_strobe |-> $stable({mode_cmd_hi, mode_cmd_lo}); endproperty
  a_cmd_stable: assert property (p_cmd_stable) else $error("command bits moved");
  property p_sclk_idle; cs_n |-> !sclk; endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock while deselected");
  property p_sclk_half; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
  a_sclk_half: assert property (p_sclk_half) else $error("serial clock half period off");
  property p_frame_len; $rose(cs_n) |-> sck_reg == FRAME_BITS; endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame bit count off");

  c_cont: cover property (deint_up && trigger);
  c_frame: cover property ($rose(cs_n));
  c_cmd: cover property ($rose(cmd_strobe));
endmodule

// ### msadc_tb_top.sv
// testbench: apb-driven controller facing the converter sequencer across the link
`timescale 1ns/1ps
module msadc_tb_top
  import msadc_pkg::*;
;
  // short phases keep the run small
  localparam int AZ = 8;
  localparam int IN = 16;
  localparam int DE = 16;

  typedef struct packed {
    logic [1:0]  cmd;
    logic        cmp;
    logic [19:0] pos;
    logic [19:0] neg;
  } msadc_row_t;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, cmp_pos, rd_err;
  logic [7:0]  paddr;
  logic        az_on, in_on, pref_on, nref_on;
  logic [31:0] pwdata, prdata, rd_data;
  int          n_fail, tests_run;
  time         t_first;
  msadc_row_t  rows [6];

  msadc_if link ();
  msadc_device #(.AZ_CYC(AZ), .INT_CYC(IN), .DEINT_CYC(DE)) u_msadc_device (
    .pclk(pclk), .presetn(presetn), .link(link), .cmp_pos(cmp_pos),
    .az_sw_on(az_on), .input_sw_on(in_on), .pos_ref_on(pref_on), .neg_ref_on(nref_on));
  msadc_host u_msadc_host (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .link(link));
  msadc_checker #(.AZ_CYC(AZ), .INT_CYC(IN), .DEINT_CYC(DE)) u_msadc_checker (
    .pclk(pclk), .presetn(presetn), .trigger(link.trigger), .mode_cmd_hi(link.mode_cmd_hi),
    .mode_cmd_lo(link.mode_cmd_lo), .cmd_strobe(link.cmd_strobe), .done_n(link.done_n),
    .deintegrate_start_n(link.deintegrate_start_n), .sclk(link.sclk), .cs_n(link.cs_n));

  initial begin
    pclk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // polls a status bit; a lost event counts as a mismatch and ends the run
  task automatic wait_st(input int b);
    for (int i = 0; i < 200; i++) begin
      apb(1'b0, OFS_STATUS, '0);
      if (rd_data[b] === 1'b1) return;
    end
    n_fail++;
    end_sim();
  endtask

  // a short trigger pulse gives exactly one reading
  task automatic convert();
    apb(1'b1, OFS_STATUS, 32'h0000_0007);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    apb(1'b0, OFS_CTRL, '0);
    apb(1'b1, OFS_CTRL, '0);
    wait_st(ST_DONE);
  endtask

  task automatic idle_chk();
    chk(link.done_n, 1'b1);
    chk(link.deintegrate_start_n, 1'b1);
    chk(link.cs_n, 1'b1);
    chk({az_on, in_on, pref_on, nref_on}, 4'b1000);
    apb(1'b0, OFS_STATUS, '0);
    chk(rd_data, 32'h0000_0030);
    chk(irq, 1'b0);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #(1_000_000);
    n_fail++;
    end_sim();
  end

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    cmp_pos = 1'b0;
    n_fail  = 0;
    tests_run = 0;
    // mode, comparator, expected counts: integrate 16 cycles, deintegrate 16
    rows = '{'{2'h0, 1'h1, 20'h0_0000, 20'h0_0010}, '{2'h0, 1'h0, 20'h0_0010, 20'h0_0000},
             '{2'h1, 1'h1, 20'h0_0010, 20'h0_0020}, '{2'h2, 1'h0, 20'h0_0000, 20'h0_0000},
             '{2'h1, 1'h0, 20'h0_0020, 20'h0_0010}, '{2'h3, 1'h0, 20'h0_0020, 20'h0_0010}};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    idle_chk();
    apb(1'b0, 8'h1C, '0);
    chk(rd_err, 1'b1);
    chk(rd_data, 32'h0000_0000);
    $display("reset and unmapped test done");
    foreach (rows[i]) begin
      apb(1'b1, OFS_CMD, 32'(rows[i].cmd));
      cmp_pos <= rows[i].cmp;
      convert();
      apb(1'b1, OFS_READ, '0);
      wait_st(ST_RDDONE);
      apb(1'b0, OFS_POS, '0);
      chk(rd_data, 32'(rows[i].pos));
      apb(1'b0, OFS_NEG, '0);
      chk(rd_data, 32'(rows[i].neg));
      apb(1'b0, OFS_STATUS, '0);
      chk(rd_data[ST_DONE_L], 1'b0);
      $display("row %0d done", i);
    end
    // masked event stays quiet, unmasking raises it, clearing drops it
    apb(1'b1, OFS_CMD, '0);
    apb(1'b1, OFS_MASK, '0);
    convert();
    chk(irq, 1'b0);
    apb(1'b1, OFS_MASK, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, OFS_STATUS, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    $display("interrupt test done");
    // a command during readout must be dropped
    apb(1'b1, OFS_READ, '0);
    apb(1'b1, OFS_CMD, 32'h0000_0002);
    wait_st(ST_RDDONE);
    apb(1'b0, OFS_CMD, '0);
    chk(rd_data, 32'h0000_0000);
    $display("busy test done");
    // held trigger: readings follow with no gap
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    @(negedge link.done_n);
    t_first = $time;
    @(negedge link.done_n);
    chk(32'(($time - t_first) / CLK_PERIOD_NS), 32'(AZ + IN + DE));
    // switch drives of the next reading, measure mode, comparator low
    @(posedge link.done_n);
    @(negedge pclk);
    chk({az_on, in_on, pref_on, nref_on}, 4'b0100);
    @(negedge link.deintegrate_start_n);
    @(negedge pclk);
    chk({az_on, in_on, pref_on, nref_on}, 4'b0010);
    apb(1'b1, OFS_CTRL, '0);
    $display("continuous test done");
    // reset in mid-reading returns both ends to idle
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    repeat (20) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(link.trigger, 1'b0);
    presetn <= 1'b1;
    idle_chk();
    $display("mid-run reset test done");
    end_sim();
  end
endmodule
